// >>> verilog/pcd_consts.svh
`ifndef PCD_CONSTS_SVH
`define PCD_CONSTS_SVH

// Register byte offsets
`define PCD_OFS_CMD 8'h00
`define PCD_OFS_LEN 8'h04
`define PCD_OFS_DATA0 8'h08
`define PCD_OFS_DATA1 8'h0C
`define PCD_OFS_DATA2 8'h10
`define PCD_OFS_DATA3 8'h14
`define PCD_OFS_STATUS 8'h18
`define PCD_OFS_USAGE 8'h1C

// Command and length register fields
`define PCD_CMD_GO_BIT 31
`define PCD_LEN_LE_BIT 8

// Coded parameter values
`define PCD_LC_CHANGE 8'h10
`define PCD_LC_SINGLE 8'h08
`define PCD_P1_PLAIN 8'h00
`define PCD_USE_REPLACE 8'h08
`define PCD_USE_NONE 8'h00
`define PCD_RETRY_INIT 2'h3
`define PCD_RETRY_ZERO 2'h0
`define PCD_REF_NONE 5'h00

// Reset values
`define PCD_CMD_RST 32'h0000_0000
`define PCD_WORD_RST 32'h0000_0000

`endif

// >>> verilog/pcd_pkg.sv
`default_nettype none
package pcd_pkg;

    typedef enum logic [1:0] {
        PCD_OP_CHANGE = 2'h0,
        PCD_OP_DISABLE = 2'h1,
        PCD_OP_ENABLE = 2'h2,
        PCD_OP_PROVISION = 2'h3
    } pcd_op_t;

    typedef enum logic [2:0] {
        PCD_RES_OK = 3'h0,
        PCD_RES_MISMATCH = 3'h1,
        PCD_RES_BLOCKED_NOW = 3'h2,
        PCD_RES_REFUSED = 3'h3,
        PCD_RES_BAD_PARAM = 3'h4
    } pcd_res_t;

    typedef enum logic [1:0] {
        PCD_ST_IDLE = 2'b00,
        PCD_ST_EXEC = 2'b01,
        PCD_ST_DONE = 2'b11
    } pcd_state_t;

    typedef struct packed {
        pcd_op_t op;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] lc;
        logic le_present;
    } pcd_cmd_t;

    typedef struct packed {
        logic enabled;
        logic blocked;
        logic [1:0] retries;
        logic alt_active;
        logic [4:0] alt_ref;
    } pcd_slot_t;

endpackage : pcd_pkg

`default_nettype wire

// >>> verilog/pcd_pin_cmd.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"

module pcd_pin_cmd
    import pcd_pkg::*;
#(
    parameter int PIN_W = 64
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Security environment
    output logic se_revalidate_out,
    output logic busy_out
);

    generate
        if (PIN_W != 64) begin : g_bad_width
            $error("pcd_pin_cmd: PIN field must be 8 bytes");
        end
    endgenerate

    // Slot index: b8 of P2 and the five reference bits
    localparam int SLOTS = 64;
    localparam int KEYS = 32;

    // Held through reset: models non-volatile store, so counts survive sessions
    logic [PIN_W-1:0] pin_val_mem [SLOTS];
    pcd_slot_t slot_mem [SLOTS];
    logic [7:0] usage_mem [KEYS];

    pcd_state_t state_r;
    pcd_cmd_t cmd_r;
    logic [31:0] data_r [4];
    logic [7:0] len_r;
    logic len_le_r;
    logic [4:0] usage_sel_r;
    pcd_res_t result_r;
    logic done_r;
    logic [5:0] last_slot_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic reval_r;
    logic busy_r;

    logic apb_acc;
    logic apb_wr;
    logic go_take;
    logic addr_ok;
    logic [31:0] rd_data;
    logic [5:0] slot_idx;
    pcd_slot_t cur;
    logic [PIN_W-1:0] old_val;
    logic [PIN_W-1:0] new_val;
    logic match;
    logic p2_ok;
    logic params_ok;
    logic state_ok;
    logic [1:0] retries_dec;
    pcd_slot_t slot_nxt;
    pcd_res_t result_nxt;
    logic write_val;
    logic write_use;
    logic [4:0] use_idx;
    logic [7:0] use_val;
    logic access_open;

    // Answer one cycle into the access phase
    assign apb_acc = psel_in && penable_in && !pready_r;
    assign apb_wr = apb_acc && pwrite_in;
    // Go taken on the first access cycle, while the bus still holds it
    assign go_take = apb_wr && paddr_in == `PCD_OFS_CMD && pwdata_in[`PCD_CMD_GO_BIT];

    always_comb begin
        addr_ok = 1'b1;
        rd_data = `PCD_WORD_RST;
        unique case (paddr_in)
            `PCD_OFS_CMD: rd_data = {1'b0, 7'h00, cmd_r.p2, cmd_r.p1, 6'h00, cmd_r.op};
            `PCD_OFS_LEN: rd_data = {23'h00_0000, len_le_r, len_r};
            `PCD_OFS_DATA0: rd_data = data_r[0];
            `PCD_OFS_DATA1: rd_data = data_r[1];
            `PCD_OFS_DATA2: rd_data = data_r[2];
            `PCD_OFS_DATA3: rd_data = data_r[3];
            `PCD_OFS_STATUS: rd_data = {16'h0000, access_open, cur.alt_active, cur.blocked, cur.enabled,
                                        2'b00, cur.retries, 1'b0, result_r, 2'b00, done_r, busy_r};
            `PCD_OFS_USAGE: rd_data = {16'h0000, usage_mem[usage_sel_r], 3'h0, usage_sel_r};
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= apb_acc;
        end
    end

    // Error only with the answer, never on its own
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= apb_acc && !addr_ok;
        end
    end

    // Read data zero outside the answer, so stale words never leak
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_r <= `PCD_WORD_RST;
        end else begin
            prdata_r <= (apb_acc && !pwrite_in && addr_ok) ? rd_data : `PCD_WORD_RST;
        end
    end

    // Software-side registers; command and data frozen while busy
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_r <= '0;
            len_r <= 8'h00;
            len_le_r <= 1'b0;
            usage_sel_r <= `PCD_REF_NONE;
            for (int i = 0; i < 4; i++) begin
                data_r[i] <= `PCD_WORD_RST;
            end
        end else if (apb_wr && state_r == PCD_ST_IDLE) begin
            unique case (paddr_in)
                `PCD_OFS_CMD: begin
                    cmd_r.op <= pcd_op_t'(pwdata_in[1:0]);
                    cmd_r.p1 <= pwdata_in[15:8];
                    cmd_r.p2 <= pwdata_in[23:16];
                end
                `PCD_OFS_LEN: begin
                    len_r <= pwdata_in[7:0];
                    len_le_r <= pwdata_in[`PCD_LEN_LE_BIT];
                end
                `PCD_OFS_DATA0: data_r[0] <= pwdata_in;
                `PCD_OFS_DATA1: data_r[1] <= pwdata_in;
                `PCD_OFS_DATA2: data_r[2] <= pwdata_in;
                `PCD_OFS_DATA3: data_r[3] <= pwdata_in;
                `PCD_OFS_USAGE: usage_sel_r <= pwdata_in[4:0];
                default: ;
            endcase
        end
    end

    // Decode of the addressed PIN and its parameters
    always_comb begin
        slot_idx = {cmd_r.p2[7], cmd_r.p2[4:0]};
        cur = slot_mem[last_slot_r];
        old_val = {data_r[0], data_r[1]};
        new_val = {data_r[2], data_r[3]};
        access_open = !cur.enabled && !cur.alt_active;
        p2_ok = (cmd_r.p2[6:5] == 2'b00) && (cmd_r.p2[4:0] != `PCD_REF_NONE);
        params_ok = 1'b0;
        unique case (cmd_r.op)
            PCD_OP_CHANGE: params_ok = (cmd_r.p1 == `PCD_P1_PLAIN) && (len_r == `PCD_LC_CHANGE) && !len_le_r;
            PCD_OP_DISABLE: params_ok = (len_r == `PCD_LC_SINGLE) && !len_le_r
                && ((cmd_r.p1 == `PCD_P1_PLAIN)
                    || (cmd_r.p1[7] && cmd_r.p1[6:5] == 2'b00 && cmd_r.p1[4:0] != `PCD_REF_NONE));
            PCD_OP_ENABLE: params_ok = (cmd_r.p1 == `PCD_P1_PLAIN) && (len_r == `PCD_LC_SINGLE) && !len_le_r;
            PCD_OP_PROVISION: params_ok = 1'b1;
        endcase
        params_ok = params_ok && p2_ok;
    end

    // Compare and state update against the stored value
    always_comb begin
        pcd_slot_t s;
        s = slot_mem[slot_idx];
        match = (pin_val_mem[slot_idx] == old_val);
        retries_dec = s.retries - 2'h1;
        slot_nxt = s;
        result_nxt = PCD_RES_OK;
        write_val = 1'b0;
        write_use = 1'b0;
        use_idx = s.alt_ref;
        use_val = `PCD_USE_NONE;
        state_ok = 1'b0;
        unique case (cmd_r.op)
            PCD_OP_CHANGE: state_ok = s.enabled && !s.blocked;
            PCD_OP_DISABLE: state_ok = s.enabled && !s.blocked;
            PCD_OP_ENABLE: state_ok = !s.enabled && !s.blocked;
            PCD_OP_PROVISION: state_ok = 1'b1;
        endcase
        if (!params_ok) begin
            result_nxt = PCD_RES_BAD_PARAM;
        end else if (!state_ok) begin
            result_nxt = PCD_RES_REFUSED;
        end else if (cmd_r.op == PCD_OP_PROVISION) begin
            // Stand-in for unblock: fresh value, counter full, enabled
            write_val = 1'b1;
            slot_nxt.enabled = 1'b1;
            slot_nxt.blocked = 1'b0;
            slot_nxt.retries = `PCD_RETRY_INIT;
            slot_nxt.alt_active = 1'b0;
            slot_nxt.alt_ref = `PCD_REF_NONE;
        end else if (match) begin
            slot_nxt.retries = `PCD_RETRY_INIT;
            unique case (cmd_r.op)
                PCD_OP_CHANGE: write_val = 1'b1;
                PCD_OP_DISABLE: begin
                    slot_nxt.enabled = 1'b0;
                    if (cmd_r.p1[7]) begin
                        slot_nxt.alt_active = 1'b1;
                        slot_nxt.alt_ref = cmd_r.p1[4:0];
                        write_use = 1'b1;
                        use_idx = cmd_r.p1[4:0];
                        use_val = `PCD_USE_REPLACE;
                    end
                end
                PCD_OP_ENABLE: begin
                    slot_nxt.enabled = 1'b1;
                    slot_nxt.alt_active = 1'b0;
                    write_use = s.alt_active;
                    use_val = `PCD_USE_NONE;
                end
                default: ;
            endcase
        end else begin
            // Enabled flag untouched on mismatch; option not taken
            slot_nxt.retries = retries_dec;
            result_nxt = PCD_RES_MISMATCH;
            if (retries_dec == `PCD_RETRY_ZERO) begin
                slot_nxt.blocked = 1'b1;
                result_nxt = PCD_RES_BLOCKED_NOW;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= PCD_ST_IDLE;
        end else begin
            unique case (state_r)
                PCD_ST_IDLE: if (go_take) begin
                    state_r <= PCD_ST_EXEC;
                end
                PCD_ST_EXEC: state_r <= PCD_ST_DONE;
                PCD_ST_DONE: state_r <= PCD_ST_IDLE;
                default: state_r <= PCD_ST_IDLE;
            endcase
        end
    end

    // Storage updates, single cycle so the next command sees them
    always_ff @(posedge core_clk_in) begin
        if (state_r == PCD_ST_EXEC) begin
            slot_mem[slot_idx] <= slot_nxt;
            if (write_val) begin
                pin_val_mem[slot_idx] <= (cmd_r.op == PCD_OP_PROVISION) ? old_val : new_val;
            end
            if (write_use) begin
                usage_mem[use_idx] <= use_val;
            end
        end
    end

    // Result and slot of the last executed command
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_r <= PCD_RES_OK;
            last_slot_r <= 6'h00;
        end else if (state_r == PCD_ST_EXEC) begin
            result_r <= result_nxt;
            last_slot_r <= slot_idx;
        end
    end

    // Done stands until the next go, so a slow poll still sees it
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_r <= 1'b0;
        end else if (state_r == PCD_ST_EXEC) begin
            done_r <= 1'b1;
        end else if (state_r == PCD_ST_IDLE && go_take) begin
            done_r <= 1'b0;
        end
    end

    // Busy rises on the go edge itself, so a second go is shut out
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_r <= 1'b0;
        end else if (state_r == PCD_ST_IDLE) begin
            busy_r <= go_take;
        end else begin
            busy_r <= (state_r == PCD_ST_EXEC);
        end
    end

    // Environment re-check only once a disable or enable took effect
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reval_r <= 1'b0;
        end else begin
            reval_r <= (state_r == PCD_ST_EXEC) && params_ok && state_ok && match
                && (cmd_r.op == PCD_OP_DISABLE || cmd_r.op == PCD_OP_ENABLE);
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign se_revalidate_out = reval_r;
    assign busy_out = busy_r;

endmodule : pcd_pin_cmd

`default_nettype wire

// >>> verif/pcd_pin_cmd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_pin_cmd_chk
    import pcd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Security environment
    input wire logic se_revalidate_out,
    input wire logic busy_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence go_taken;
        psel_in && penable_in && pwrite_in && !pready_out && !busy_out && paddr_in == 8'h00 && pwdata_in[31];
    endsequence
    sequence cmd_span;
        busy_out [*2] ##[1:3] !busy_out;
    endsequence
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held two cycles");
    chk_ready_timing: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready late");
    chk_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
        else $error("ready without access");
    chk_err_qualified: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    chk_rdata_quiet: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
        else $error("read data outside answer");
    chk_go_busy: assert property (go_taken |=> busy_out)
        else $error("go not taken");
    chk_busy_span: assert property (go_taken |=> cmd_span)
        else $error("busy span wrong");
    chk_reval_pulse: assert property (se_revalidate_out |=> !se_revalidate_out)
        else $error("revalidate too long");
    chk_reval_cause: assert property (se_revalidate_out |-> $past(busy_out))
        else $error("revalidate without command");
endmodule : pcd_pin_cmd_chk

bind pcd_pin_cmd pcd_pin_cmd_chk pcd_pin_cmd_chk_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .se_revalidate_out(se_revalidate_out), .busy_out(busy_out));
`default_nettype wire

// >>> verif/pcd_terminal_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"
module pcd_terminal_model (
    // Clock
    input wire logic clk_in,
    // APB master
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0000_0000;
    end
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdat,
                        output logic [31:0] rdat, output logic err);
        int n;
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= wr;
        paddr_out <= addr;
        pwdata_out <= wdat;
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 16);
        if (n >= 16)
            test_pin_change_disable_enable.give_up();
        rdat = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // Released address and data lines never keep the old value
        paddr_out <= ~addr;
        pwdata_out <= ~wdat;
    endtask : xfer
    task automatic apdu(input logic [1:0] op, input logic [7:0] p1, p2, lc,
                        input logic [127:0] dat, output logic [31:0] st);
        logic [31:0] q;
        logic e;
        int n;
        for (int i = 0; i < 4; i++)
            xfer(1'b1, 8'h08 + 8'(4 * i), dat[127 - 32 * i -: 32], q, e);
        xfer(1'b1, `PCD_OFS_LEN, {24'h00_0000, lc}, q, e);
        xfer(1'b1, `PCD_OFS_CMD, {8'h80, p2, p1, 6'h00, op}, q, e);
        n = 0;
        do begin
            xfer(1'b0, `PCD_OFS_STATUS, 32'h0000_0000, st, e);
            n++;
        end while (st[1:0] !== 2'b10 && n < 16);
        if (n >= 16)
            test_pin_change_disable_enable.give_up();
    endtask : apdu
endmodule : pcd_terminal_model
`default_nettype wire

// >>> verif/test_pin_change_disable_enable.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"
module test_pin_change_disable_enable;
    import pcd_pkg::*;
    localparam logic [63:0] PA = 64'h3132_3334_FFFF_FFFF;
    localparam logic [63:0] PB = 64'h3939_3939_FFFF_FFFF;
    localparam logic [63:0] PC = 64'h3530_3132_3334_FFFF;
    localparam logic [63:0] Z = 64'h0000_0000_0000_0000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, reval, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_total = 0;
    int n_tests = 0;
    int reval_cnt = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (reval === 1'b1)
            reval_cnt++;
    end
    pcd_pin_cmd pcd_pin_cmd_i (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .se_revalidate_out(reval), .busy_out(busy));
    pcd_terminal_model pcd_terminal_model_i (.clk_in(clk), .psel_out(psel), .penable_out(penable),
        .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
        .pslverr_in(pslverr));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic give_up();
        err_total++;
        $display("[FAIL] wait expected answer seen none");
        tally_and_finish();
    endtask : give_up
    task automatic check(input string nm, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Status fields 15:4 hold access, alt, blocked, enabled, retries, result
    task automatic run(input string nm, input logic [1:0] op, input logic [7:0] p1, p2, lc,
                       input logic [127:0] dat, input pcd_res_t res, input logic [1:0] ret,
                       input logic en, bl, al);
        logic [31:0] st;
        pcd_terminal_model_i.apdu(op, p1, p2, lc, dat, st);
        check(nm, 32'({~en & ~al, al, bl, en, 2'b00, ret, 1'b0, res}), 32'(st[15:4]));
    endtask : run
    task automatic usage(input logic [7:0] exp);
        logic [31:0] q;
        logic e;
        pcd_terminal_model_i.xfer(1'b1, `PCD_OFS_USAGE, 32'h0000_0005, q, e);
        pcd_terminal_model_i.xfer(1'b0, `PCD_OFS_USAGE, 32'h0000_0000, q, e);
        check("usage", 32'(exp), 32'(q[15:8]));
    endtask : usage
    task automatic power_cycle();
        logic [31:0] q;
        logic e;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        pcd_terminal_model_i.xfer(1'b0, `PCD_OFS_CMD, 32'h0000_0000, q, e);
        check("cmd reset2", `PCD_CMD_RST, q);
    endtask : power_cycle
    task automatic t_bus();
        logic [31:0] q;
        logic e;
        pcd_terminal_model_i.xfer(1'b0, 8'h20, 32'h0000_0000, q, e);
        check("unmapped err", 32'h0000_0001, 32'(e));
        check("unmapped data", 32'h0000_0000, q);
        pcd_terminal_model_i.xfer(1'b0, `PCD_OFS_CMD, 32'h0000_0000, q, e);
        check("cmd reset", `PCD_CMD_RST, q);
    endtask : t_bus
    task automatic t_change();
        run("prov", PCD_OP_PROVISION, 8'h00, 8'h81, 8'h08, {PA, Z}, PCD_RES_OK, 2'h3, 1, 0, 0);
        run("chg bad1", PCD_OP_CHANGE, 8'h00, 8'h81, 8'h10, {PB, PC}, PCD_RES_MISMATCH, 2'h2, 1, 0, 0);
        run("chg bad2", PCD_OP_CHANGE, 8'h00, 8'h81, 8'h10, {PB, PC}, PCD_RES_MISMATCH, 2'h1, 1, 0, 0);
        run("chg ok", PCD_OP_CHANGE, 8'h00, 8'h81, 8'h10, {PA, PB}, PCD_RES_OK, 2'h3, 1, 0, 0);
        run("chg old", PCD_OP_CHANGE, 8'h00, 8'h81, 8'h10, {PA, PC}, PCD_RES_MISMATCH, 2'h2, 1, 0, 0);
        run("chg new", PCD_OP_CHANGE, 8'h00, 8'h81, 8'h10, {PB, PC}, PCD_RES_OK, 2'h3, 1, 0, 0);
    endtask : t_change
    task automatic t_disable();
        int n;
        n = reval_cnt;
        run("dis ok", PCD_OP_DISABLE, 8'h00, 8'h81, 8'h08, {PC, Z}, PCD_RES_OK, 2'h3, 0, 0, 0);
        run("dis again", PCD_OP_DISABLE, 8'h00, 8'h81, 8'h08, {PC, Z}, PCD_RES_REFUSED, 2'h3, 0, 0, 0);
        run("chg off", PCD_OP_CHANGE, 8'h00, 8'h81, 8'h10, {PC, PA}, PCD_RES_REFUSED, 2'h3, 0, 0, 0);
        run("en bad1", PCD_OP_ENABLE, 8'h00, 8'h81, 8'h08, {PA, Z}, PCD_RES_MISMATCH, 2'h2, 0, 0, 0);
        run("en bad2", PCD_OP_ENABLE, 8'h00, 8'h81, 8'h08, {PA, Z}, PCD_RES_MISMATCH, 2'h1, 0, 0, 0);
        run("en bad3", PCD_OP_ENABLE, 8'h00, 8'h81, 8'h08, {PA, Z}, PCD_RES_BLOCKED_NOW, 2'h0, 0, 1, 0);
        run("en blk", PCD_OP_ENABLE, 8'h00, 8'h81, 8'h08, {PC, Z}, PCD_RES_REFUSED, 2'h0, 0, 1, 0);
        check("reval dis", 32'(n + 1), 32'(reval_cnt));
    endtask : t_disable
    task automatic t_replace();
        int n;
        run("prov2", PCD_OP_PROVISION, 8'h00, 8'h02, 8'h08, {PA, Z}, PCD_RES_OK, 2'h3, 1, 0, 0);
        run("en on", PCD_OP_ENABLE, 8'h00, 8'h02, 8'h08, {PA, Z}, PCD_RES_REFUSED, 2'h3, 1, 0, 0);
        n = reval_cnt;
        run("dis alt", PCD_OP_DISABLE, 8'h85, 8'h02, 8'h08, {PA, Z}, PCD_RES_OK, 2'h3, 0, 0, 1);
        usage(`PCD_USE_REPLACE);
        run("en alt", PCD_OP_ENABLE, 8'h00, 8'h02, 8'h08, {PA, Z}, PCD_RES_OK, 2'h3, 1, 0, 0);
        usage(`PCD_USE_NONE);
        check("reval alt", 32'(n + 2), 32'(reval_cnt));
    endtask : t_replace
    task automatic t_block();
        run("dis bad1", PCD_OP_DISABLE, 8'h00, 8'h02, 8'h08, {PB, Z}, PCD_RES_MISMATCH, 2'h2, 1, 0, 0);
        run("dis bad2", PCD_OP_DISABLE, 8'h00, 8'h02, 8'h08, {PB, Z}, PCD_RES_MISMATCH, 2'h1, 1, 0, 0);
        power_cycle();
        run("dis bad3", PCD_OP_DISABLE, 8'h00, 8'h02, 8'h08, {PB, Z}, PCD_RES_BLOCKED_NOW, 2'h0, 1, 1, 0);
        run("dis blk", PCD_OP_DISABLE, 8'h00, 8'h02, 8'h08, {PA, Z}, PCD_RES_REFUSED, 2'h0, 1, 1, 0);
    endtask : t_block
    task automatic t_param();
        run("prov3", PCD_OP_PROVISION, 8'h00, 8'h02, 8'h08, {PA, Z}, PCD_RES_OK, 2'h3, 1, 0, 0);
        run("p1 rsvd", PCD_OP_DISABLE, 8'h01, 8'h02, 8'h08, {PA, Z}, PCD_RES_BAD_PARAM, 2'h3, 1, 0, 0);
        run("p2 rfu", PCD_OP_CHANGE, 8'h00, 8'h42, 8'h10, {PA, PB}, PCD_RES_BAD_PARAM, 2'h3, 1, 0, 0);
        run("lc bad", PCD_OP_CHANGE, 8'h00, 8'h02, 8'h08, {PA, PB}, PCD_RES_BAD_PARAM, 2'h3, 1, 0, 0);
        run("en p1", PCD_OP_ENABLE, 8'h01, 8'h02, 8'h08, {PA, Z}, PCD_RES_BAD_PARAM, 2'h3, 1, 0, 0);
    endtask : t_param
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_bus();
        t_change();
        t_disable();
        t_replace();
        t_block();
        t_param();
        tally_and_finish();
    end
endmodule : test_pin_change_disable_enable
`default_nettype wire
